// file: common/gvp_consts.svh
// Purpose: constants of the grouped vectored interrupt prioritizer
// Assumes: byte offsets on the register port, 32-bit words
// Notes: definitions only
`ifndef GVP_CONSTS_SVH
`define GVP_CONSTS_SVH

`define GVP_NUM_GROUPS 64
`define GVP_LINES_PER_GROUP 32
`define GVP_NUM_LINES 2048
`define GVP_NUM_LEVELS 4
`define GVP_LAST_GROUP 6'h3F

`define GVP_ADDR_W 10
`define GVP_IPR_FIRST 10'h000
`define GVP_IPR_LAST 10'h0FC
`define GVP_IRR_FIRST 10'h100
`define GVP_IRR_LAST 10'h1FC
`define GVP_ICR_FIRST 10'h200
`define GVP_ICR_LAST 10'h20C

`define GVP_IPR_LEVEL_HI 31
`define GVP_IPR_LEVEL_LO 30
`define GVP_IPR_OFFSET_HI 13
`define GVP_IPR_OFFSET_LO 0
`define GVP_ICR_CAUSE_HI 5
`define GVP_ICR_CAUSE_LO 0

`define GVP_IPR_RESET 32'h00000000
`define GVP_LEVEL_RESET 2'h0
`define GVP_OFFSET_RESET 14'h0000
`define GVP_RDATA_RESET 32'h00000000
`define GVP_ICR_TOP_LEVEL 2'h3

`define GVP_LEVEL_LOWEST 2'h0
`define GVP_LEVEL_1 2'h1
`define GVP_LEVEL_2 2'h2
`define GVP_LEVEL_HIGHEST 2'h3

`endif

// file: common/gvp_pkg.sv
// Purpose: shared types of the grouped vectored interrupt prioritizer
// Assumes: constants come from gvp_consts.svh
// Notes: widths are fixed
package gvp_pkg;
    typedef logic [1:0] gvp_level_type;
    typedef logic [5:0] gvp_group_type;
    typedef logic [13:0] gvp_offset_type;
    typedef logic [31:0] gvp_word_type;
endpackage

// file: design/gvp_first_set.sv
// Purpose: finds the lowest set bit of the 64 group flags
// Assumes: purely combinational
// Notes: idx is zero when nothing is set
`timescale 1ns/1ps
`default_nettype none
module gvp_first_set
    import gvp_pkg::*;
(
    // flags in
    input wire logic [63:0] vec,
    // result
    output logic found,
    output gvp_group_type idx
);
    always_comb begin
        idx = 6'h00;
        for (int i = 63; i >= 0; i--) begin
            if (vec[i]) begin
                idx = 6'(i);
            end
        end
    end

    assign found = |vec;
endmodule
`default_nettype wire

// file: design/gvp_irq_prioritizer.sv
// Purpose: grouped vectored interrupt prioritizer, 64 groups of 32 lines plus one non-maskable line
// Assumes: request lines are asynchronous to clk; mask bits come from processor logic on clk
// Notes: sync_clk_en low models the stopped sampling clock; reg_if_en low models the gated bus clock
`timescale 1ns/1ps
`default_nettype none
`include "gvp_consts.svh"

// Behaviour
// - accepts 64 groups, each of 32 peripheral request lines.
// - each group holds a writable level and handler offset register.
// - every request line is sampled continuously into its group's readable request register.
// - group pending is the OR of all lines of that group.
// - each pending group is placed at one of four levels by its level field.
// - a request is masked when the global mask or its level mask is set.
// - a valid request is flagged for each pending group at an unmasked level.
// - highest valid level wins; a pending non-maskable request beats all.
// - among groups at the winning level the lowest group number wins.
// - one cause register per level gives the lowest pending group there.
// - processor sees request, level and handler offset of the winner.
// - request to processor rises three sampling cycles after a line rises.
// - handler offset is meaningless while a non-maskable request is presented.
// - sampling and prioritizing halt while the sampling clock is stopped.
// - operation continues unchanged while the processor is held in debug.
// - register interface runs after reset and may be gated off later.
// - level code 00 is lowest priority, 11 is highest.
// - a cause value means something only while that level has a request.
module gvp_irq_prioritizer
    import gvp_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // clock gating
    input wire logic sync_clk_en,
    input wire logic reg_if_en,
    // peripheral requests
    input wire logic [2047:0] periph_req_line,
    input wire logic nonmaskable_req_line,
    // processor status mask bits
    input wire logic global_irq_mask,
    input wire logic level3_mask,
    input wire logic level2_mask,
    input wire logic level1_mask,
    input wire logic level0_mask,
    // register port
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [9:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    output gvp_word_type reg_rdata,
    // request to processor
    output logic cpu_irq_req,
    output logic cpu_irq_nmi,
    output gvp_level_type cpu_prio_level,
    output gvp_offset_type cpu_handler_offset
);
    // masking decision, used for groups and for levels
    function automatic logic level_masked(input gvp_level_type lvl, input logic gm, input logic [3:0] lm);
        level_masked = gm | lm[lvl];
    endfunction

    // synchroniser and request register storage
    logic [2047:0] req_meta_q;
    logic [2047:0] group_request_reg_q;
    logic nmi_meta_q;
    logic nmi_sync_q;

    // per-group programmable storage
    gvp_level_type prio_level_q [`GVP_NUM_GROUPS];
    gvp_offset_type handler_off_q [`GVP_NUM_GROUPS];

    // output stage
    logic irq_req_q;
    logic irq_nmi_q;
    gvp_level_type irq_level_q;
    gvp_offset_type irq_off_q;
    gvp_word_type rdata_q;

    // combinational nets
    logic [3:0] level_mask;
    // bitwise driven from generate loops, so kept as packed nets
    wire logic [63:0] group_pending;
    wire logic [63:0] group_valid_req;
    wire logic [3:0][63:0] lvl_pend;
    wire logic [3:0] cause_found;
    wire logic [3:0][5:0] cause_idx;
    wire logic [3:0] lvl_valid;
    logic win_any;
    gvp_level_type win_level;
    gvp_group_type win_group;
    gvp_offset_type win_offset;
    logic irq_req_d;
    gvp_level_type irq_level_d;
    gvp_offset_type irq_off_d;

    // register port decode
    logic acc_ok;
    logic aligned;
    logic ipr_hit;
    logic irr_hit;
    logic icr_hit;
    gvp_group_type word_idx;
    gvp_level_type icr_level;
    logic ipr_wr;
    gvp_word_type ipr_rd_word;
    gvp_word_type irr_rd_word;
    gvp_word_type icr_rd_word;
    gvp_word_type rdata_d;

    assign level_mask = {level3_mask, level2_mask, level1_mask, level0_mask};

    // two-stage sampling of all lines; the second stage is the request register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            req_meta_q <= '0;
            group_request_reg_q <= '0;
            nmi_meta_q <= 1'b0;
            nmi_sync_q <= 1'b0;
        end else if (sync_clk_en) begin
            req_meta_q <= periph_req_line;
            group_request_reg_q <= req_meta_q;
            nmi_meta_q <= nonmaskable_req_line;
            nmi_sync_q <= nmi_meta_q;
        end
    end

    // group OR and level placement
    for (genvar g = 0; g < `GVP_NUM_GROUPS; g++) begin : g_grp
        assign group_pending[g] = |group_request_reg_q[g*`GVP_LINES_PER_GROUP +: `GVP_LINES_PER_GROUP];
        assign group_valid_req[g] = group_pending[g]
            & ~level_masked(prio_level_q[g], global_irq_mask, level_mask);
        for (genvar l = 0; l < `GVP_NUM_LEVELS; l++) begin : g_lvl
            assign lvl_pend[l][g] = group_pending[g] & (prio_level_q[g] == 2'(l));
        end
    end

    // lowest pending group per level
    for (genvar l = 0; l < `GVP_NUM_LEVELS; l++) begin : g_cause
        gvp_first_set u_first (
            .vec(lvl_pend[l]),
            .found(cause_found[l]),
            .idx(cause_idx[l])
        );
        assign lvl_valid[l] = cause_found[l] & ~level_masked(2'(l), global_irq_mask, level_mask);
    end

    // highest unmasked level wins; code 3 is highest
    assign win_any = |group_valid_req;
    assign win_level = lvl_valid[3] ? `GVP_LEVEL_HIGHEST :
                       lvl_valid[2] ? `GVP_LEVEL_2 :
                       lvl_valid[1] ? `GVP_LEVEL_1 : `GVP_LEVEL_LOWEST;
    assign win_group = cause_idx[win_level];
    assign win_offset = handler_off_q[win_group];

    // non-maskable request overrides everything; its offset is driven as zero
    assign irq_req_d = nmi_sync_q | win_any;
    assign irq_level_d = nmi_sync_q ? `GVP_LEVEL_HIGHEST : win_level;
    assign irq_off_d = nmi_sync_q ? `GVP_OFFSET_RESET : win_offset;

    // third sampling-clock stage towards the processor
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irq_req_q <= 1'b0;
            irq_nmi_q <= 1'b0;
            irq_level_q <= `GVP_LEVEL_RESET;
            irq_off_q <= `GVP_OFFSET_RESET;
        end else if (sync_clk_en) begin
            irq_req_q <= irq_req_d;
            irq_nmi_q <= nmi_sync_q;
            irq_level_q <= irq_level_d;
            irq_off_q <= irq_off_d;
        end
    end

    // no debug input exists, so debug halt of the processor changes nothing here
    assign cpu_irq_req = irq_req_q;
    assign cpu_irq_nmi = irq_nmi_q;
    assign cpu_prio_level = irq_level_q;
    assign cpu_handler_offset = irq_off_q;

    // register port: accesses count only while the bus clock runs
    assign acc_ok = reg_if_en;
    assign aligned = (reg_addr[1:0] == 2'h0);
    assign ipr_hit = aligned && (reg_addr <= `GVP_IPR_LAST);
    assign irr_hit = aligned && (reg_addr >= `GVP_IRR_FIRST) && (reg_addr <= `GVP_IRR_LAST);
    assign icr_hit = aligned && (reg_addr >= `GVP_ICR_FIRST) && (reg_addr <= `GVP_ICR_LAST);
    assign word_idx = reg_addr[7:2];
    assign icr_level = `GVP_ICR_TOP_LEVEL - reg_addr[3:2];
    assign ipr_wr = acc_ok & reg_wr_en & ipr_hit;

    // per-group level and offset registers
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            for (int g = 0; g < `GVP_NUM_GROUPS; g++) begin
                prio_level_q[g] <= `GVP_LEVEL_RESET;
                handler_off_q[g] <= `GVP_OFFSET_RESET;
            end
        end else if (ipr_wr) begin
            prio_level_q[word_idx] <= reg_wdata[`GVP_IPR_LEVEL_HI:`GVP_IPR_LEVEL_LO];
            handler_off_q[word_idx] <= reg_wdata[`GVP_IPR_OFFSET_HI:`GVP_IPR_OFFSET_LO];
        end
    end

    // read words
    always_comb begin
        ipr_rd_word = `GVP_IPR_RESET;
        ipr_rd_word[`GVP_IPR_LEVEL_HI:`GVP_IPR_LEVEL_LO] = prio_level_q[word_idx];
        ipr_rd_word[`GVP_IPR_OFFSET_HI:`GVP_IPR_OFFSET_LO] = handler_off_q[word_idx];
        icr_rd_word = `GVP_RDATA_RESET;
        icr_rd_word[`GVP_ICR_CAUSE_HI:`GVP_ICR_CAUSE_LO] = cause_idx[icr_level];
    end

    assign irr_rd_word = group_request_reg_q[word_idx*`GVP_LINES_PER_GROUP +: `GVP_LINES_PER_GROUP];
    assign rdata_d = ipr_hit ? ipr_rd_word :
                     irr_hit ? irr_rd_word :
                     icr_hit ? icr_rd_word : `GVP_RDATA_RESET;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata_q <= `GVP_RDATA_RESET;
        end else if (acc_ok && reg_rd_en) begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;
endmodule
`default_nettype wire

// file: testbench/gvp_cpu_model.sv
// Purpose: processor exception side of the prioritizer
// Assumes: accepts in one cycle when no higher exception
// Notes: nmi uses a fixed vector, so it is not taken here
`timescale 1ns/1ps
`default_nettype none
module gvp_cpu_model #(parameter logic [31:0] VECTOR_BASE = 32'h80000000) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // from prioritizer
    input wire logic irq_req,
    input wire logic irq_nmi,
    input wire logic [1:0] irq_level,
    input wire logic [13:0] irq_offset,
    // test controls
    input wire logic exc_pending,
    input wire logic gm_set,
    input wire logic masks_clr,
    // status mask bits and handler address
    output logic gm_q,
    output logic [3:0] lvl_mask_q,
    output logic [31:0] handler_addr_q
);
    wire accept = irq_req && !irq_nmi && !exc_pending;
    wire [3:0] new_mask = lvl_mask_q | (4'hF >> (2'h3 - irq_level));
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            gm_q <= 1'b0;
            lvl_mask_q <= 4'h0;
            handler_addr_q <= 32'h00000000;
        end else if (masks_clr) begin
            gm_q <= 1'b0;
            lvl_mask_q <= 4'h0;
        end else if (accept) begin
            lvl_mask_q <= new_mask;
            handler_addr_q <= VECTOR_BASE | {18'h00000, irq_offset};
        end else if (gm_set) begin
            gm_q <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// file: testbench/gvp_irq_prioritizer_chk.sv
// Purpose: port assertions of the prioritizer
// Assumes: one clock domain
// Notes: bound from tb
`timescale 1ns/1ps
`default_nettype none
module gvp_irq_prioritizer_chk
    import gvp_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // enables and requests
    input wire logic sync_clk_en,
    input wire logic reg_if_en,
    input wire logic nonmaskable_req_line,
    // mask bits
    input wire logic global_irq_mask,
    input wire logic level3_mask,
    input wire logic level0_mask,
    // register port
    input wire logic reg_rd_en,
    input wire logic [9:0] reg_addr,
    input wire gvp_word_type reg_rdata,
    // processor side
    input wire logic cpu_irq_req,
    input wire logic cpu_irq_nmi,
    input wire gvp_level_type cpu_prio_level,
    input wire gvp_offset_type cpu_handler_offset
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    nmi_wins_a: assert property (cpu_irq_nmi |-> cpu_irq_req && cpu_prio_level == 2'h3)
        else $error("nmi not presented at top level");
    nmi_offset_a: assert property (cpu_irq_nmi |-> cpu_handler_offset == 14'h0000)
        else $error("offset not zero during nmi");
    nmi_delay_a: assert property ($rose(nonmaskable_req_line) ##0
        (nonmaskable_req_line && sync_clk_en)[*3] |=> cpu_irq_nmi) else $error("nmi late");
    global_mask_a: assert property (global_irq_mask && sync_clk_en |=> cpu_irq_req == cpu_irq_nmi)
        else $error("request passed global mask");
    top_mask_a: assert property (level3_mask && sync_clk_en |=>
        !cpu_irq_req || cpu_irq_nmi || cpu_prio_level != 2'h3) else $error("level 3 not masked");
    low_mask_a: assert property (level0_mask && sync_clk_en |=>
        !cpu_irq_req || cpu_irq_nmi || cpu_prio_level != 2'h0) else $error("level 0 not masked");
    sleep_freeze_a: assert property (!sync_clk_en |=> $stable(cpu_irq_req)
        && $stable(cpu_prio_level) && $stable(cpu_handler_offset)) else $error("outputs moved in sleep");
    rdata_hold_a: assert property (!(reg_rd_en && reg_if_en) |=> $stable(reg_rdata))
        else $error("read data changed without read");
    unmapped_read_a: assert property (reg_rd_en && reg_if_en && reg_addr >= 10'h210
        |=> reg_rdata == 32'h00000000) else $error("unmapped read not zero");
endmodule
`default_nettype wire

// file: testbench/tb.sv
// Purpose: self-checking bench of the prioritizer
// Assumes: inputs change at falling edges
// Notes: the processor model owns the mask bits
`timescale 1ns/1ps
`default_nettype none
module tb;
    import gvp_pkg::*;
    localparam logic [31:0] VB = 32'h80000000;
    logic clk = 1'b0, nrst = 1'b0, sync_en = 1'b1, rif_en = 1'b1, wr = 1'b0, rd = 1'b0, nml = 1'b0;
    logic exc = 1'b1, gm_set = 1'b0, m_clr = 1'b0, irq, nmi, gm;
    logic [2047:0] req = {2048{1'b0}};
    logic [9:0] addr = 10'h000;
    logic [31:0] wdata = 32'h00000000, haddr;
    logic [3:0] lm;
    gvp_word_type rdata;
    gvp_level_type lvl;
    gvp_offset_type off;
    int fail_count = 0;
    int n_checks = 0;
    gvp_irq_prioritizer gvp_irq_prioritizer_inst (.clk(clk), .nrst(nrst), .sync_clk_en(sync_en),
        .reg_if_en(rif_en), .periph_req_line(req), .nonmaskable_req_line(nml), .global_irq_mask(gm),
        .level3_mask(lm[3]), .level2_mask(lm[2]), .level1_mask(lm[1]), .level0_mask(lm[0]),
        .reg_wr_en(wr), .reg_rd_en(rd), .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata),
        .cpu_irq_req(irq), .cpu_irq_nmi(nmi), .cpu_prio_level(lvl), .cpu_handler_offset(off));
    gvp_cpu_model #(.VECTOR_BASE(VB)) gvp_cpu_model_inst (.clk(clk), .nrst(nrst), .irq_req(irq),
        .irq_nmi(nmi), .irq_level(lvl), .irq_offset(off), .exc_pending(exc), .gm_set(gm_set),
        .masks_clr(m_clr), .gm_q(gm), .lvl_mask_q(lm), .handler_addr_q(haddr));
    initial begin
        forever #12.5 clk = ~clk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    // write when w is high, else read and compare with d
    task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr = w;
        rd = !w;
        @(negedge clk);
        wr = 1'b0;
        rd = 1'b0;
        if (!w) begin
            chk(rdata, d);
        end
    endtask
    task automatic pulse_exc;
        exc = 1'b0;
        cyc(1);
        exc = 1'b1;
    endtask
    task automatic clr_masks;
        m_clr = 1'b1;
        cyc(1);
        m_clr = 1'b0;
        cyc(2);
    endtask
    task automatic t_regs;
        bus(1'b0, 10'h014, 32'h00000000);
        bus(1'b1, 10'h004, 32'hC0000100);
        bus(1'b0, 10'h004, 32'hC0000100);
        bus(1'b1, 10'h100, 32'hFFFFFFFF);
        bus(1'b0, 10'h100, 32'h00000000);
        bus(1'b0, 10'h210, 32'h00000000);
        rif_en = 1'b0;
        bus(1'b1, 10'h008, 32'h40000010);
        rif_en = 1'b1;
        bus(1'b0, 10'h008, 32'h00000000);
    endtask
    task automatic t_latency;
        bus(1'b1, 10'h008, 32'hC0000100);
        req[64] = 1'b1;
        cyc(2);
        chk(irq, 32'h1 ^ 32'h1);
        cyc(1);
        chk(irq, 32'h1);
        chk({off, lvl}, {16'h0000, 14'h0100, 2'h3});
        bus(1'b0, 10'h108, 32'h00000001);
        bus(1'b0, 10'h200, 32'h00000002);
        req[64] = 1'b0;
        bus(1'b0, 10'h108, 32'h00000001);
        cyc(4);
        chk(irq, 32'h0);
    endtask
    task automatic t_prio;
        bus(1'b1, 10'h00C, 32'h40000030);
        bus(1'b1, 10'h028, 32'h40000050);
        bus(1'b1, 10'h01C, 32'h80000070);
        req[101] = 1'b1;
        req[351] = 1'b1;
        req[233] = 1'b1;
        req[2047] = 1'b1;
        cyc(4);
        chk({off, lvl}, {16'h0000, 14'h0070, 2'h2});
        req[233] = 1'b0;
        cyc(4);
        chk({off, lvl}, {16'h0000, 14'h0030, 2'h1});
        bus(1'b0, 10'h208, 32'h00000003);
        bus(1'b0, 10'h20C, 32'h0000003F);
        bus(1'b0, 10'h10C, 32'h00000020);
        gm_set = 1'b1;
        cyc(1);
        gm_set = 1'b0;
        cyc(2);
        chk(irq, 32'h0);
        clr_masks();
    endtask
    task automatic t_accept;
        pulse_exc();
        chk(lm, 32'h3);
        chk(haddr, VB | 32'h30);
        cyc(2);
        chk(irq, 32'h0);
        req[64] = 1'b1;
        cyc(4);
        chk({irq, lvl}, {29'h0, 1'b1, 2'h3});
        pulse_exc();
        chk(lm, 32'hF);
        chk(haddr, VB | 32'h100);
        cyc(2);
        chk(irq, 32'h0);
        req = {2048{1'b0}};
        clr_masks();
    endtask
    task automatic t_nmi;
        gm_set = 1'b1;
        nml = 1'b1;
        cyc(2);
        gm_set = 1'b0;
        chk(nmi, 32'h0);
        cyc(1);
        chk({nmi, irq, lvl, off}, {14'h0, 4'hF, 14'h0000});
        nml = 1'b0;
        cyc(4);
        chk({nmi, irq}, 32'h0);
        clr_masks();
    endtask
    task automatic t_sleep;
        sync_en = 1'b0;
        req[64] = 1'b1;
        cyc(5);
        chk(irq, 32'h0);
        sync_en = 1'b1;
        cyc(3);
        chk(irq, 32'h1);
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        cyc(2);
        nrst = 1'b1;
        t_regs();
        t_latency();
        t_prio();
        t_accept();
        t_nmi();
        t_sleep();
        stop_test();
    end
    initial begin
        repeat (3000) @(posedge clk);
        fail_count++;
        $display("unexpected at %0t: watchdog expired", $time);
        stop_test();
    end
endmodule
bind gvp_irq_prioritizer gvp_irq_prioritizer_chk gvp_irq_prioritizer_chk_inst (.clk(clk), .nrst(nrst),
    .sync_clk_en(sync_clk_en), .reg_if_en(reg_if_en), .nonmaskable_req_line(nonmaskable_req_line),
    .global_irq_mask(global_irq_mask), .level3_mask(level3_mask), .level0_mask(level0_mask),
    .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_rdata(reg_rdata), .cpu_irq_req(cpu_irq_req),
    .cpu_irq_nmi(cpu_irq_nmi), .cpu_prio_level(cpu_prio_level), .cpu_handler_offset(cpu_handler_offset));
`default_nettype wire
